// file: src/fsr_pkg.sv
package fsr_pkg;
  // =====================================================
  // status byte field positions
  localparam int BIT_READY = 7;
  localparam int BIT_ERS_SUSP = 6;
  localparam int BIT_ERS_ERR = 5;
  localparam int BIT_PRG_ERR = 4;
  localparam int BIT_PEN_ERR = 3;
  localparam int BIT_PRG_SUSP = 2;
  localparam int BIT_PROT_ERR = 1;
  localparam logic [7:0] ERR_MASK = 8'h3A;
  localparam logic [7:0] RSVD_MASK = 8'hFE;

  // =====================================================
  // flash command codes issued on the data lines
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;

  // =====================================================
  // controller register map (byte offsets, compared with wb_adr_i[3:0])
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_ADDR = 4'h4;
  localparam logic [3:0] OFS_DATA = 4'h8;
  localparam logic [3:0] OFS_STAT = 4'hC;
  // ctrl bits: 0 go, 1 write-cycle, 2 poll-until-ready, 3 clear-status
  localparam int CTRL_GO = 0;
  localparam int CTRL_WR = 1;
  localparam int CTRL_POLL = 2;
  localparam int CTRL_CLR = 3;

  // =====================================================
  // bus cycle timing
  localparam int T_STROBE_NS = 120;
  localparam int CLK_NS = 40;
  localparam logic [3:0] STROBE_CYC = 4'((T_STROBE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [23:0] RESET_ADDR = 24'h00_0000;

  // =====================================================
  // flash pin group
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [23:0] addr;
  } fsr_pins_t;
endpackage

// file: src/fsr_host.sv
// The register addresses and register access over Wishbone are this design's own decisions.
`timescale 1ns/100ps
// Functional notes
// - read status at previous operation address
// - poll bit 7, then check errors
// - clear errors before new operations
// - mask reserved bit 0
module fsr_host (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  output fsr_pkg::fsr_pins_t flash_o,
  input wire logic [7:0] low_data_byte_lines_i,
  output logic [7:0] low_data_byte_lines_o,
  output logic low_data_byte_lines_oe_o
);
  typedef enum logic [2:0] {S_IDLE, S_SETUP, S_STROBE, S_GAP, S_CLR} fsr_state_t;

  fsr_state_t state_reg;
  logic [23:0] addr_reg;
  logic [7:0] wdata_reg;
  logic [7:0] status_reg;
  logic [7:0] err_reg;
  logic wr_reg, poll_reg, clr_reg, busy_reg, done_reg;
  logic clr_cyc_reg;
  logic [3:0] cnt_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;
  fsr_pkg::fsr_pins_t pins_reg;
  logic [7:0] dq_reg;
  logic dq_oe_reg;

  // decode for a register offset, used by the write and go paths; the read mux decodes wb_adr_i[3:0] itself
  function automatic logic hit(input logic [31:0] a, input logic [3:0] ofs);
    hit = (a[3:0] == ofs);
  endfunction

  wire wb_req = wb_cyc_i && wb_stb_i && !ack_reg;
  wire wb_wr = wb_req && wb_we_i && wb_sel_i[0];
  wire start = wb_wr && hit(wb_adr_i, fsr_pkg::OFS_CTRL) && wb_dat_i[fsr_pkg::CTRL_GO]
               && !busy_reg;
  wire sample = (state_reg == S_STROBE) && (cnt_reg == 4'h1) && !wr_reg;
  // reserved bit masked off the captured byte
  wire [7:0] rd_byte = low_data_byte_lines_i & fsr_pkg::RSVD_MASK;

  // =====================================================
  // wishbone slave: one-cycle ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= wb_req;
    end
  end

  // read mux
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_reg <= 32'h0000_0000;
    end else if (wb_req) begin
      unique case (wb_adr_i[3:0])
        fsr_pkg::OFS_CTRL: rdata_reg <= {28'h000_0000, clr_reg, poll_reg, wr_reg, busy_reg};
        fsr_pkg::OFS_ADDR: rdata_reg <= {8'h00, addr_reg};
        fsr_pkg::OFS_DATA: rdata_reg <= {24'h00_0000, wdata_reg};
        fsr_pkg::OFS_STAT: rdata_reg <= {16'h0000, err_reg, status_reg};
        default: rdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  // address and data registers; address is kept for status reads
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      addr_reg <= fsr_pkg::RESET_ADDR;
      wdata_reg <= 8'h00;
    end else if (wb_wr && !busy_reg) begin
      if (hit(wb_adr_i, fsr_pkg::OFS_ADDR)) addr_reg <= wb_dat_i[23:0];
      if (hit(wb_adr_i, fsr_pkg::OFS_DATA)) wdata_reg <= wb_dat_i[7:0];
    end
  end

  // =====================================================
  // flash bus cycle sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= S_IDLE;
      cnt_reg <= 4'h0;
      wr_reg <= 1'b0;
      poll_reg <= 1'b0;
      clr_reg <= 1'b0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      clr_cyc_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        S_IDLE: begin
          if (start) begin
            wr_reg <= wb_dat_i[fsr_pkg::CTRL_WR];
            poll_reg <= wb_dat_i[fsr_pkg::CTRL_POLL];
            clr_reg <= wb_dat_i[fsr_pkg::CTRL_CLR];
            busy_reg <= 1'b1;
            done_reg <= 1'b0;
            clr_cyc_reg <= 1'b0;
            state_reg <= S_SETUP;
          end
        end
        S_SETUP: begin
          cnt_reg <= fsr_pkg::STROBE_CYC;
          state_reg <= S_STROBE;
        end
        S_STROBE: begin
          cnt_reg <= cnt_reg - 4'h1;
          if (cnt_reg == 4'h1) state_reg <= S_GAP;
        end
        S_GAP: begin
          // each poll re-strobes output enable for a fresh value
          if (!wr_reg && poll_reg && !status_reg[fsr_pkg::BIT_READY]) begin
            state_reg <= S_SETUP;
          end else if (clr_reg) begin
            // clear errors after the operation, before the next one
            wr_reg <= 1'b1;
            clr_reg <= 1'b0;
            clr_cyc_reg <= 1'b1; // held until the next go
            state_reg <= S_CLR;
          end else begin
            busy_reg <= 1'b0;
            done_reg <= 1'b1;
            state_reg <= S_IDLE;
          end
        end
        S_CLR: state_reg <= S_SETUP;
      endcase
    end
  end

  // pin drive: chip select low in setup and strobe, read strobe for the whole strobe phase, write strobe for all but its last cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pins_reg <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: fsr_pkg::RESET_ADDR};
      dq_reg <= 8'h00;
      dq_oe_reg <= 1'b0;
    end else begin
      pins_reg.addr <= addr_reg;
      pins_reg.ce_n <= !(state_reg == S_SETUP || state_reg == S_STROBE);
      pins_reg.oe_n <= !(state_reg == S_STROBE && !wr_reg);
      pins_reg.we_n <= !(state_reg == S_STROBE && wr_reg && cnt_reg != 4'h1);
      dq_oe_reg <= wr_reg && (state_reg == S_SETUP || state_reg == S_STROBE);
      // clear cycle sends the clear code, every other write the data byte
      dq_reg <= clr_cyc_reg ? fsr_pkg::CMD_CLEAR_STATUS : wdata_reg;
    end
  end

  // status capture; error bits only meaningful once ready
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_reg <= 8'h00;
      err_reg <= 8'h00;
    end else if (sample) begin
      status_reg <= rd_byte;
      if (rd_byte[fsr_pkg::BIT_READY]) begin
        err_reg <= rd_byte & fsr_pkg::ERR_MASK;
      end
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;
  assign flash_o = pins_reg;
  assign low_data_byte_lines_o = dq_reg;
  assign low_data_byte_lines_oe_o = dq_oe_reg;

  // =====================================================
  // checks
  a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
  a_oe_drive_excl: assert property (@(posedge clk_i) disable iff (rst_i)
    !(low_data_byte_lines_oe_o && !flash_o.oe_n)) else $error("bus contention");
  a_err_after_ready: assert property (@(posedge clk_i) disable iff (rst_i)
    $changed(err_reg) |-> status_reg[fsr_pkg::BIT_READY]) else $error("errors taken while busy");
  a_rsvd_low: assert property (@(posedge clk_i) disable iff (rst_i)
    !status_reg[0]) else $error("reserved bit kept");
  a_poll_restrobe: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_reg == S_GAP && poll_reg && !wr_reg && !status_reg[fsr_pkg::BIT_READY])
    |=> state_reg == S_SETUP ##1 state_reg == S_STROBE) else $error("poll not repeated");
  a_oe_width: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(flash_o.oe_n) |-> !flash_o.oe_n [*3]) else $error("read strobe short");
  a_ce_with_oe: assert property (@(posedge clk_i) disable iff (rst_i)
    !flash_o.oe_n |-> !flash_o.ce_n) else $error("oe without select");
  a_done_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(done_reg) |-> !busy_reg && state_reg == S_IDLE) else $error("done while busy");
  a_clr_code: assert property (@(posedge clk_i) disable iff (rst_i)
    (clr_cyc_reg && !flash_o.we_n) |-> low_data_byte_lines_o == fsr_pkg::CMD_CLEAR_STATUS)
    else $error("clear code not driven");
  a_addr_stable: assert property (@(posedge clk_i) disable iff (rst_i)
    !flash_o.ce_n |-> $stable(flash_o.addr)) else $error("address moved in cycle");
  a_sample_in_oe: assert property (@(posedge clk_i) disable iff (rst_i)
    sample |-> !flash_o.oe_n && !flash_o.ce_n) else $error("status taken outside read");
  a_we_data_drive: assert property (@(posedge clk_i) disable iff (rst_i)
    !flash_o.we_n |-> low_data_byte_lines_oe_o) else $error("write strobe undriven");
endmodule

// file: verification/fsr_flash_model.sv
`timescale 1ns/100ps
module fsr_flash_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input fsr_pkg::fsr_pins_t pins_i,
  input wire logic [7:0] line_i,
  input wire logic [7:0] err_i,
  input wire logic [7:0] susp_i,
  output logic [7:0] line_o
);
  logic [7:0] err_reg;
  logic [7:0] last_reg;
  logic [7:0] cmd_reg;
  logic [3:0] busy_reg;
  logic we_reg;
  // =====================================
  // command taken when write strobe ends
  always_ff @(posedge clk_i) begin
    we_reg <= pins_i.we_n;
    last_reg <= line_i;
    if (!pins_i.we_n) cmd_reg <= line_i;
    if (rst_i) begin
      err_reg <= 8'h00;
      busy_reg <= 4'h0;
    end else begin
      if (busy_reg != 4'h0) busy_reg <= busy_reg - 4'h1;
      if (pins_i.we_n && !we_reg && !pins_i.ce_n) begin
        if (cmd_reg == fsr_pkg::CMD_CLEAR_STATUS) begin
          err_reg <= 8'h00;
        end else if (cmd_reg != fsr_pkg::CMD_READ_STATUS) begin
          busy_reg <= 4'h9;
          // failures pile up onto earlier ones
          err_reg <= err_reg | (err_i & fsr_pkg::ERR_MASK);
        end
      end
    end
  end
  // =====================================
  // status drive, released lines show inverse of last level
  always_comb begin
    line_o = ~last_reg;
    if (!pins_i.ce_n && !pins_i.oe_n) begin
      if (busy_reg != 4'h0) begin
        line_o[7] = 1'b0;
      end else begin
        line_o = 8'h80 | (susp_i & 8'h44) | err_reg;
      end
    end
  end
endmodule

// file: verification/flash_status_register_test.sv
`timescale 1ns/100ps
module flash_status_register_test;
  logic clk_i = 0;
  logic rst_i = 1;
  logic [31:0] wb_adr_i = 0;
  logic [31:0] wb_dat_i = 0;
  logic wb_we_i = 0;
  logic [3:0] wb_sel_i = 0;
  logic wb_cyc_i = 0;
  logic wb_stb_i = 0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  fsr_pkg::fsr_pins_t flash_o;
  logic [7:0] host_d, dev_d, err_i = 0, susp_i = 0, acc, s;
  logic host_oe;
  logic [7:0] line;
  logic [23:0] a_exp;
  logic [31:0] seed = 32'hd6c7_743a;
  logic [31:0] rd;
  logic [7:0] pat [7] = '{8'h20, 8'h30, 8'h28, 8'h22, 8'h10, 8'h18, 8'h12};
  int n_mismatch = 0;
  int num_checks = 0;
  assign line = host_oe ? host_d : dev_d;
  always #20 clk_i = ~clk_i;
  fsr_host DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .flash_o(flash_o), .low_data_byte_lines_i(line),
    .low_data_byte_lines_o(host_d), .low_data_byte_lines_oe_o(host_oe));
  fsr_flash_model model (.clk_i(clk_i), .rst_i(rst_i), .pins_i(flash_o), .line_i(line),
    .err_i(err_i), .susp_i(susp_i), .line_o(dev_d));
  function logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task results;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // =====================================
  // classic wishbone single cycle
  task wb(input logic we, input logic [3:0] a, input logic [31:0] d);
    int t;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} <= {2'b11, we, 4'hf};
    wb_adr_i <= {28'h000_0000, a};
    wb_dat_i <= d;
    t = 0;
    do begin @(posedge clk_i); t++; end while (wb_ack_o !== 1'b1 && t < 50);
    if (t >= 50) begin
      n_mismatch++;
      results;
    end
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  // start a flash cycle and wait until not busy
  task run(input logic [3:0] c);
    int k;
    wb(1'b1, fsr_pkg::OFS_CTRL, {28'h000_0000, c});
    k = 0;
    do begin wb(1'b0, fsr_pkg::OFS_CTRL, 0); k++; end while (rd[0] !== 1'b0 && k < 200);
    if (k >= 200) begin
      n_mismatch++;
      results;
    end
  endtask
  // program command, polled status read, optional clear
  task op(input logic [7:0] e, input logic clr);
    seed = lfsr(seed);
    a_exp = seed[23:0];
    s = seed[31:24] & 8'h44;
    err_i <= e;
    susp_i <= s;
    wb(1'b1, fsr_pkg::OFS_ADDR, {8'h00, a_exp});
    wb(1'b1, fsr_pkg::OFS_DATA, 32'h0000_0040);
    run(4'h3);
    run(clr ? 4'hD : 4'h5);
    acc = acc | (e & fsr_pkg::ERR_MASK);
    wb(1'b0, fsr_pkg::OFS_STAT, 0);
    check({24'h00_0000, rd[7:0]}, {24'h00_0000, 8'h80 | s | acc});
    check({24'h00_0000, rd[15:8]}, {24'h00_0000, acc});
    if (clr) acc = 8'h00;
  endtask
  // reads go to the address of the operation
  always @(posedge clk_i) begin
    if (!rst_i && !flash_o.ce_n && !flash_o.oe_n) check({8'h00, flash_o.addr}, {8'h00, a_exp});
  end
  initial begin
    #2_000_000;
    n_mismatch++;
    results;
  end
  initial begin
    acc = 8'h00;
    a_exp = 24'h00_0000;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    check({4'h0, flash_o, host_oe}, 32'h0e00_0000);
    wb(1'b0, 4'h2, 0);
    check(rd, 32'h0000_0000);
    for (int i = 0; i < 7; i++) op(pat[i], 1'b1);
    op(8'h00, 1'b0);
    op(8'h18, 1'b0);
    op(8'h22, 1'b1);
    op(8'h01, 1'b0);
    op(8'h30, 1'b0);
    rst_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    acc = 8'h00;
    op(8'h00, 1'b0);
    results;
  end
endmodule
